// ==== rtl/pc_stack_regs.svh ====
// Constants for the program counter, return stack and indirect addressing unit
`ifndef PC_STACK_REGS_SVH
`define PC_STACK_REGS_SVH
`define PC_WIDTH 13
`define PC_LOW_WIDTH 8
`define PC_UPPER_WIDTH 5
`define PAGE_TARGET_WIDTH 11
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3
`define DATA_ADDR_WIDTH 9
`define PC_RESET_VALUE 13'h0000
`define LATCH_RESET_VALUE 8'h00
`define WINDOW_READ_VALUE 8'h00
`define WINDOW_POINTER 8'h00
`endif

// ==== rtl/pc_stack_pkg.sv ====
// Types shared by the program counter and stack unit
package pc_stack_pkg;
    // Program flow request from the instruction decoder
    typedef struct packed {
        logic fetch;
        logic low_write;
        logic jump;
        logic call;
        logic intr;
        logic ret;
        logic [10:0] target;
        logic [12:0] vector;
        logic [7:0] low_data;
    } flow_req_t;
    // Indirect data access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic bank_pointer_bit;
        logic [7:0] file_pointer;
    } ind_req_t;
    // Indirect data access result toward the register file
    typedef struct packed {
        logic [8:0] addr;
        logic rd;
        logic wr;
        logic window_self;
    } ind_rsp_t;
    // Kind of program counter update
    typedef enum {PC_HOLD, PC_SEQ, PC_LOW, PC_JUMP, PC_PUSH_JUMP, PC_POP} pc_op_t;
endpackage : pc_stack_pkg

// ==== rtl/program_counter_stack_unit.sv ====
// Program counter, circular return stack and indirect address former
`timescale 1ns/100ps
`default_nettype none
`include "pc_stack_regs.svh"
module program_counter_stack_unit #(
    parameter int STACK_DEPTH = `STACK_DEPTH
) (
    input wire logic clk_sys_in, // Core clock 40 MHz
    input wire logic rstn_in, // Async reset, active low
    input wire logic clk_en_in, // Freezes all state when low
    input wire pc_stack_pkg::flow_req_t flow_in, // Decoder flow request
    input wire logic latch_wr_in, // Write high-byte latch
    input wire logic [7:0] latch_data_in, // Latch write data
    input wire pc_stack_pkg::ind_req_t ind_in, // Indirect access request
    input wire logic [7:0] ind_rdata_in, // Data read from register file
    output logic [12:0] pc_out, // Full program counter
    output logic [7:0] pc_low_byte_out, // Readable low byte
    output logic [7:0] pc_high_latch_out, // Latch readback
    output pc_stack_pkg::ind_rsp_t ind_out, // Indirect access toward file
    output logic [7:0] ind_rdata_out // Indirect read result
);
    import pc_stack_pkg::*;

    localparam int PW = $clog2(STACK_DEPTH);

    logic [12:0] pc_reg;
    logic [12:0] pc_next;
    logic [7:0] pc_high_latch_reg;
    logic [12:0] stack_reg [STACK_DEPTH];
    logic [PW-1:0] sp_reg;
    pc_op_t op;
    ind_rsp_t ind_next;
    logic [12:0] stack_top;

    // Wrapping pointer step, used for push and pop
    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic up);
        ptr_step = up ? p + 1'b1 : p - 1'b1;
    endfunction : ptr_step

    // Page-relative target for call and goto
    function automatic logic [12:0] page_target(input logic [7:0] lat, input logic [10:0] t);
        page_target = {lat[4:3], t};
    endfunction : page_target

    // Operation priority: return, push, jump, low write, fetch
    always_comb begin
        if (flow_in.ret) begin
            op = PC_POP;
        end else if (flow_in.call || flow_in.intr) begin
            op = PC_PUSH_JUMP;
        end else if (flow_in.jump) begin
            op = PC_JUMP;
        end else if (flow_in.low_write) begin
            op = PC_LOW;
        end else if (flow_in.fetch) begin
            op = PC_SEQ;
        end else begin
            op = PC_HOLD;
        end
    end

    // Next program counter value
    always_comb begin
        unique case (op)
            PC_SEQ: pc_next = pc_reg + 13'h0001;
            PC_LOW: pc_next = {pc_high_latch_reg[4:0], flow_in.low_data};
            PC_JUMP: pc_next = page_target(pc_high_latch_reg, flow_in.target);
            PC_PUSH_JUMP: pc_next = flow_in.intr ? flow_in.vector
                                  : page_target(pc_high_latch_reg, flow_in.target);
            PC_POP: pc_next = stack_reg[ptr_step(sp_reg, 1'b0)];
            PC_HOLD: pc_next = pc_reg;
        endcase
    end

    // Program counter; reset clears upper bits
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_reg <= `PC_RESET_VALUE;
        end else if (clk_en_in) begin
            pc_reg <= pc_next;
        end
    end

    // High-byte latch, written only by software
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_high_latch_reg <= `LATCH_RESET_VALUE;
        end else if (clk_en_in && latch_wr_in) begin
            pc_high_latch_reg <= latch_data_in;
        end
    end

    // Circular stack storage; a call pushes the address after current, an interrupt pushes the current address
    always_ff @(posedge clk_sys_in) begin
        if (clk_en_in && op == PC_PUSH_JUMP) begin
            stack_reg[sp_reg] <= flow_in.intr ? pc_reg : pc_reg + 13'h0001;
        end
    end

    // Hidden stack pointer, wraps silently
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sp_reg <= '0;
        end else if (clk_en_in) begin
            if (op == PC_PUSH_JUMP) begin
                sp_reg <= ptr_step(sp_reg, 1'b1);
            end else if (op == PC_POP) begin
                sp_reg <= ptr_step(sp_reg, 1'b0);
            end
        end
    end

    // Indirect address forming and window self-access
    always_comb begin
        ind_next.addr = {ind_in.bank_pointer_bit, ind_in.file_pointer};
        ind_next.window_self = (ind_in.file_pointer == `WINDOW_POINTER);
        ind_next.rd = ind_in.rd && !ind_next.window_self;
        ind_next.wr = ind_in.wr && !ind_next.window_self;
    end

    // Registered indirect outputs
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ind_out <= '0;
            ind_rdata_out <= `WINDOW_READ_VALUE;
        end else if (clk_en_in) begin
            ind_out <= ind_next;
            ind_rdata_out <= ind_next.window_self ? `WINDOW_READ_VALUE : ind_rdata_in;
        end
    end

    // Registered program counter views
    always_comb begin
        pc_out = pc_reg;
        pc_low_byte_out = pc_reg[7:0];
        pc_high_latch_out = pc_high_latch_reg;
        stack_top = stack_reg[ptr_step(sp_reg, 1'b0)];
    end

    // Decoded steps used by the checks
    sequence call_s;
        clk_en_in && op == PC_PUSH_JUMP && !flow_in.intr;
    endsequence
    sequence intr_s;
        clk_en_in && op == PC_PUSH_JUMP && flow_in.intr;
    endsequence
    sequence ret_s;
        clk_en_in && op == PC_POP;
    endsequence
    sequence seq_s;
        clk_en_in && op == PC_SEQ;
    endsequence
    sequence low_s;
        clk_en_in && op == PC_LOW;
    endsequence
    sequence jump_s;
        clk_en_in && op == PC_JUMP;
    endsequence

    // Reset clears the upper counter bits
    AST_RESET_CLEAR: assert property (
        @(posedge clk_sys_in)
        $rose(rstn_in) |-> pc_reg[12:8] == 5'h00)
        else $error("upper bits not cleared at reset");

    // Sequential increment
    AST_SEQ_INC: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        seq_s |=> pc_reg == $past(pc_reg) + 13'h0001)
        else $error("fetch increment wrong");

    // Increment wraps at the top of program space
    AST_SEQ_WRAP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && op == PC_SEQ && pc_reg == 13'h1fff |=> pc_reg == 13'h0000)
        else $error("fetch wrap wrong");

    // Low write loads latch bits into upper bits
    AST_LOW_WRITE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        low_s |=> pc_reg[12:8] == $past(pc_high_latch_reg[4:0]))
        else $error("low write did not copy latch");

    // Low write sets the low byte
    AST_LOW_BYTE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        low_s |=> pc_reg[7:0] == $past(flow_in.low_data))
        else $error("low byte write wrong");

    // Jump page from latch
    AST_JUMP_PAGE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        jump_s |=> pc_reg[12:11] == $past(pc_high_latch_reg[4:3]))
        else $error("jump page wrong");

    // Jump offset from the instruction
    AST_JUMP_TARGET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        jump_s |=> pc_reg[10:0] == $past(flow_in.target))
        else $error("jump target wrong");

    // Call lands on the paged target
    AST_CALL_TARGET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        call_s |=> pc_reg == {$past(pc_high_latch_reg[4:3]), $past(flow_in.target)})
        else $error("call target wrong");

    // Interrupt lands on its vector
    AST_INTR_VECTOR: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        intr_s |=> pc_reg == $past(flow_in.vector))
        else $error("interrupt vector wrong");

    // Call stores the address after itself
    AST_CALL_PUSH: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        call_s |=> stack_reg[$past(sp_reg)] == $past(pc_reg) + 13'h0001)
        else $error("call push value wrong");

    // Interrupt stores the current address
    AST_INTR_PUSH: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        intr_s |=> stack_reg[$past(sp_reg)] == $past(pc_reg))
        else $error("interrupt push value wrong");

    // Call then return restores address after call
    AST_CALL_RET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        call_s ##1 ret_s |=> pc_reg == $past(pc_reg, 2) + 13'h0001)
        else $error("return address wrong");

    // Interrupt then return resumes at the interrupted address
    AST_INTR_RET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        intr_s ##1 ret_s |=> pc_reg == $past(pc_reg, 2))
        else $error("interrupt return address wrong");

    // Return restores all bits from the top entry
    AST_POP_VALUE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ret_s |=> pc_reg == $past(stack_top))
        else $error("pop value wrong");

    // Stack ops leave latch alone
    AST_LATCH_KEEP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && !latch_wr_in |=> pc_high_latch_reg == $past(pc_high_latch_reg))
        else $error("latch changed without write");

    // Latch takes software data
    AST_LATCH_LOAD: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && latch_wr_in |=> pc_high_latch_reg == $past(latch_data_in))
        else $error("latch write wrong");

    // Pointer wraps on call
    AST_SP_WRAP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        call_s |=> sp_reg == ptr_step($past(sp_reg), 1'b1))
        else $error("stack pointer step wrong");

    // Pointer wraps on interrupt
    AST_SP_INTR: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        intr_s |=> sp_reg == ptr_step($past(sp_reg), 1'b1))
        else $error("stack pointer interrupt step wrong");

    // Pointer steps back silently on return
    AST_SP_POP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ret_s |=> sp_reg == ptr_step($past(sp_reg), 1'b0))
        else $error("stack pointer pop step wrong");

    // Pointer idle without stack traffic
    AST_SP_HOLD: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && op inside {PC_HOLD, PC_SEQ, PC_LOW, PC_JUMP} |=> $stable(sp_reg))
        else $error("stack pointer moved");

    // Enable low freezes state
    AST_FREEZE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !clk_en_in |=> $stable(pc_reg) && $stable(sp_reg) && $stable(pc_high_latch_reg)
            && $stable(ind_out))
        else $error("state changed while frozen");

    // Counter holds with no request
    AST_HOLD_PC: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && op == PC_HOLD |=> $stable(pc_reg))
        else $error("counter moved without request");

    // Window self access reads zero and stores nothing
    AST_WINDOW_ZERO: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && ind_in.file_pointer == 8'h00 |=> ind_rdata_out == 8'h00 && !ind_out.wr)
        else $error("window self access wrong");

    // Other pointers pass the access through
    AST_WINDOW_PASS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && ind_in.file_pointer != 8'h00
            |=> ind_out.rd == $past(ind_in.rd) && ind_out.wr == $past(ind_in.wr))
        else $error("indirect strobe wrong");

    // Other pointers return file data
    AST_IND_DATA: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in && ind_in.file_pointer != 8'h00 |=> ind_rdata_out == $past(ind_rdata_in))
        else $error("indirect data wrong");

    // Address concatenation
    AST_IND_ADDR: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        clk_en_in |=> ind_out.addr == {$past(ind_in.bank_pointer_bit), $past(ind_in.file_pointer)})
        else $error("indirect address wrong");
endmodule : program_counter_stack_unit
`default_nettype wire

// ==== verification/data_file_model.sv ====
// Register file stand-in for indirect reads
`timescale 1ns/100ps
`default_nettype none
module data_file_model (
    input wire logic clk_sys_in, // Core clock
    input wire pc_stack_pkg::ind_req_t ind_in, // Indirect request
    output logic [7:0] ind_rdata_out // Same-cycle data
);
    import pc_stack_pkg::*;
    logic [7:0] churn_reg = 8'h00;
    // Filler that changes while no read is asked
    always @(posedge clk_sys_in) churn_reg <= churn_reg + 8'h3b;
    // Contents follow the nine-bit address
    assign ind_rdata_out = ind_in.rd ? ind_in.file_pointer ^ {ind_in.bank_pointer_bit, 7'h35}
        : churn_reg;
endmodule : data_file_model
`default_nettype wire

// ==== verification/program_counter_stack_unit_bench.sv ====
// Self-checking bench for the program counter and stack unit
`timescale 1ns/100ps
`default_nettype none
module program_counter_stack_unit_bench;
    import pc_stack_pkg::*;
    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] lat;
        ind_rsp_t ind;
        logic [7:0] rd;
        logic chk;
    } exp_t;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0, clk_en_in = 1'b1, latch_wr_in = 1'b0;
    flow_req_t flow_in = '0;
    ind_req_t ind_in = '0;
    logic [7:0] latch_data_in = 8'h00, ind_rdata_in, pc_low_byte_out, pc_high_latch_out;
    logic [7:0] ind_rdata_out;
    logic [12:0] pc_out, m_stk [8];
    ind_rsp_t ind_out;
    logic [2:0] m_sp;
    exp_t q [$], e, x;
    logic vld = 1'b0, vld_d = 1'b0, rnd = 1'b0;
    int seed = 86662, n_errors = 0, checks_done = 0, cyc_n = 0;
    program_counter_stack_unit i_program_counter_stack_unit (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .clk_en_in(clk_en_in), .flow_in(flow_in), .latch_wr_in(latch_wr_in),
        .latch_data_in(latch_data_in), .ind_in(ind_in), .ind_rdata_in(ind_rdata_in),
        .pc_out(pc_out), .pc_low_byte_out(pc_low_byte_out),
        .pc_high_latch_out(pc_high_latch_out), .ind_out(ind_out), .ind_rdata_out(ind_rdata_out));
    data_file_model i_data_file_model (.clk_sys_in(clk_sys_in), .ind_in(ind_in),
        .ind_rdata_out(ind_rdata_in));
    // Clock and timeout
    always #12.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        vld_d <= vld;
        cyc_n++;
        if (cyc_n == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic cmp_pc(input logic [12:0] a, input logic [12:0] b);
        checks_done++;
        if (a !== b) begin
            n_errors++;
            $display("wrong value at %0t: counter got %h expected %h", $time, a, b);
        end
    endtask : cmp_pc
    task automatic cmp_byte(input logic [7:0] a, input logic [7:0] b);
        checks_done++;
        if (a !== b) begin
            n_errors++;
            $display("wrong value at %0t: byte got %h expected %h", $time, a, b);
        end
    endtask : cmp_byte
    task automatic cmp_ind(input ind_rsp_t a, input ind_rsp_t b);
        checks_done++;
        if (a !== b) begin
            n_errors++;
            $display("wrong value at %0t: indirect got %h expected %h", $time, a, b);
        end
    endtask : cmp_ind
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Reset, model cleared, counter checked while held
    task automatic rst();
        @(posedge clk_sys_in);
        rstn_in <= 1'b0;
        vld <= 1'b0;
        flow_in <= '0;
        ind_in <= '0;
        latch_wr_in <= 1'b0;
        clk_en_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 cmp_pc(pc_out, 13'h0000);
        q.delete();
        x = '0;
        m_sp = 3'h0;
        rstn_in <= 1'b1;
    endtask : rst
    // Issue one request and note its expected outcome
    task automatic step(input int op, input logic [10:0] t, input logic [12:0] v,
        input logic [7:0] d, input logic lw);
        flow_req_t f;
        ind_req_t r;
        logic en;
        f = '0;
        f.target = t;
        f.vector = v;
        f.low_data = d;
        {f.ret, f.intr, f.call, f.jump, f.low_write, f.fetch} = 6'h01 << op;
        r.rd = 1'($random(seed));
        r.wr = ~r.rd;
        r.bank_pointer_bit = 1'($random(seed));
        r.file_pointer = (($random(seed) & 3) == 0) ? 8'h00 : 8'($random(seed));
        en = !rnd || (($random(seed) & 7) != 0);
        lw = lw && op == 0;
        if (en) begin
            case (op)
                0: x.pc = x.pc + 13'h1;
                1: x.pc = {x.lat[4:0], d};
                2: x.pc = {x.lat[4:3], t};
                3: begin
                    m_stk[m_sp] = x.pc + 13'h1;
                    m_sp = m_sp + 3'h1;
                    x.pc = {x.lat[4:3], t};
                end
                4: begin
                    m_stk[m_sp] = x.pc;
                    m_sp = m_sp + 3'h1;
                    x.pc = v;
                end
                default: begin
                    m_sp = m_sp - 3'h1;
                    x.pc = m_stk[m_sp];
                end
            endcase
            if (lw) x.lat = d;
            x.ind.addr = {r.bank_pointer_bit, r.file_pointer};
            x.ind.window_self = r.file_pointer == 8'h00;
            x.ind.rd = r.rd & ~x.ind.window_self;
            x.ind.wr = r.wr & ~x.ind.window_self;
            x.rd = x.ind.window_self ? 8'h00 : r.file_pointer ^ {r.bank_pointer_bit, 7'h35};
            x.chk = r.rd;
        end
        @(posedge clk_sys_in);
        flow_in <= f;
        ind_in <= r;
        clk_en_in <= en;
        latch_wr_in <= lw;
        latch_data_in <= d;
        vld <= 1'b1;
        q.push_back(x);
    endtask : step
    // Watcher pairs each result with the oldest note
    always @(negedge clk_sys_in) begin
        if (vld_d && rstn_in) begin
            e = q.pop_front();
            cmp_pc(pc_out, e.pc);
            cmp_byte(pc_low_byte_out, e.pc[7:0]);
            cmp_byte(pc_high_latch_out, e.lat);
            cmp_ind(ind_out, e.ind);
            if (e.chk) cmp_byte(ind_rdata_out, e.rd);
        end
    end
    // Directed wrap, paging and stack cases, then random traffic
    initial begin
        rst();
        step(0, 0, 0, 8'h1f, 1);
        step(1, 0, 0, 8'hfe, 0);
        repeat (2) step(0, 0, 0, 0, 0);
        step(0, 0, 0, 8'h10, 1);
        step(2, 11'h7ff, 0, 0, 0);
        for (int i = 0; i < 9; i++) step(3, 11'(i * 9), 0, 0, 0);
        step(4, 0, 13'h0004, 0, 0);
        repeat (10) step(5, 0, 0, 0, 0);
        rnd = 1'b1;
        repeat (80) step($unsigned($random(seed)) % 6, 11'($random(seed)),
            13'($random(seed)), 8'($random(seed)), 1'($random(seed)));
        rst();
        step(0, 0, 0, 0, 0);
        @(posedge clk_sys_in);
        vld <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        complete_run();
    end
endmodule : program_counter_stack_unit_bench
`default_nettype wire
